// ===== wws_pkg.sv
// package of constants for the windowed watchdog supervisor
//------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------
package wws_pkg;
    // ------------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int unsigned TICK_W = 8;
    // ------------------------------------------------------------------
    // documented times, counted in time base ticks of 1 us
    // ------------------------------------------------------------------
    localparam int unsigned RESET_TIMEOUT_MS = 100;
    localparam int unsigned RESET_TIMEOUT_TICKS = RESET_TIMEOUT_MS * 1000;
    localparam int unsigned FAULT_PULSE_MS = 1;
    localparam int unsigned FAULT_PULSE_TICKS = FAULT_PULSE_MS * 1000;
    localparam int unsigned FAST_LIMIT_US = 1000;
    localparam int unsigned SLOW_LIMIT_US = 10000;
    localparam int unsigned FAST_LIMIT_TICKS = FAST_LIMIT_US / TICK_US;
    localparam int unsigned SLOW_LIMIT_TICKS = SLOW_LIMIT_US / TICK_US;
    // ------------------------------------------------------------------
    // manual reset filter: least hold 1 us, glitch 100 ns
    // ------------------------------------------------------------------
    localparam int unsigned MR_HOLD_NS = 1000;
    localparam int unsigned MR_GLITCH_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MR_FILT_CYCLES =
        (MR_GLITCH_NS * 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MR_FILT_W = 8;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned SYNC_STAGES = 3;
endpackage : wws_pkg

// ===== wws_sync_if.sv
// interface carrying synchronised inputs between the supervisor modules
`timescale 1ns/100ps
interface wws_sync_if;
    logic supply_ok;
    logic kick;
    logic manual_n;
    modport producer (output supply_ok, output kick, output manual_n);
    modport consumer (input supply_ok, input kick, input manual_n);
endinterface : wws_sync_if

// ===== wws_input_sync.sv
// three-stage synchronisers for the supervisor input pins
`timescale 1ns/100ps
module wws_input_sync (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_above_threshold,
    input wire logic watchdog_kick_in,
    input wire logic manual_reset_in_n,
    wws_sync_if.producer sync
);
    localparam int N = wws_pkg::SYNC_STAGES;
    logic [N-1:0] sup_reg;
    logic [N-1:0] kick_reg;
    logic [N-1:0] mr_reg;
    logic sup_val_reg;
    logic kick_val_reg;
    logic mr_val_reg;

    // -------------------------------------------------------------
    // shift chains; stage 0 is read only by stage 1
    // -------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sup_reg <= '0;
            kick_reg <= '1;
            mr_reg <= '1;
        end else begin
            sup_reg <= {sup_reg[N-2:0], supply_above_threshold};
            kick_reg <= {kick_reg[N-2:0], watchdog_kick_in};
            mr_reg <= {mr_reg[N-2:0], manual_reset_in_n};
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sup_val_reg <= 1'b0;
            kick_val_reg <= 1'b1;
            mr_val_reg <= 1'b1;
        end else begin
            if (sup_reg[1] == sup_reg[2]) sup_val_reg <= sup_reg[2];
            if (kick_reg[1] == kick_reg[2]) kick_val_reg <= kick_reg[2];
            if (mr_reg[1] == mr_reg[2]) mr_val_reg <= mr_reg[2];
        end
    end

    assign sync.supply_ok = sup_val_reg;
    assign sync.kick = kick_val_reg;
    assign sync.manual_n = mr_val_reg;
endmodule : wws_input_sync

// ===== wws_supervisor.sv
// windowed watchdog supervisor with reset generator
`timescale 1ns/100ps
module wws_supervisor #(
    parameter int unsigned FAST_WINDOW_LIMIT = wws_pkg::FAST_LIMIT_TICKS,
    parameter int unsigned SLOW_WINDOW_LIMIT = wws_pkg::SLOW_LIMIT_TICKS,
    parameter int unsigned FAULT_PULSE_LEN = wws_pkg::FAULT_PULSE_TICKS,
    parameter int unsigned RESET_TIMEOUT = wws_pkg::RESET_TIMEOUT_TICKS,
    parameter int unsigned TICK_CYCLES = wws_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_above_threshold,
    input wire logic watchdog_kick_in,
    input wire logic manual_reset_in_n,
    output logic reset_out_n,
    output logic fault_pulse_out_n_o,
    output logic fault_pulse_out_n_oe,
    output logic fast_fault,
    output logic slow_fault
);
    localparam int CW = wws_pkg::CNT_W;
    localparam int TW = wws_pkg::TICK_W;
    localparam int FW = wws_pkg::MR_FILT_W;

    typedef enum logic [1:0] {WWS_RESET, WWS_ARMED, WWS_FAULT} wws_state_t;

    wws_sync_if sync_bus ();

    wws_input_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .supply_above_threshold(supply_above_threshold),
        .watchdog_kick_in(watchdog_kick_in),
        .manual_reset_in_n(manual_reset_in_n),
        .sync(sync_bus.producer)
    );

    wws_state_t state_reg;
    logic [TW-1:0] tick_cnt_reg;
    logic tick;
    logic [FW-1:0] mr_filt_reg;
    logic mr_low_reg;
    logic kick_prev_reg;
    logic kick_fall;
    logic [CW-1:0] rst_cnt_reg;
    logic [CW-1:0] wd_cnt_reg;
    logic [CW-1:0] pulse_cnt_reg;
    logic first_edge_reg;
    logic hold_reset;
    logic fast_hit;
    logic slow_hit;

    // saturating tick counter step
    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v,
                                               input logic t);
        sat_inc = (t && v != '1) ? v + 1'b1 : v;
    endfunction : sat_inc

    // ------------------------------------------------------------
    // time base: one tick per microsecond
    // ------------------------------------------------------------
    assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk) begin
        if (reset || tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // manual reset glitch filter
    // ------------------------------------------------------------
    // low must persist 400 ns before counting: rejects 100 ns glitches
    // and stays well inside the 1 us hold the host guarantees
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mr_filt_reg <= '0;
            mr_low_reg <= 1'b0;
        end else if (sync_bus.manual_n) begin
            mr_filt_reg <= '0;
            mr_low_reg <= 1'b0;
        end else if (mr_filt_reg == FW'(wws_pkg::MR_FILT_CYCLES)) begin
            mr_low_reg <= 1'b1;
        end else begin
            mr_filt_reg <= mr_filt_reg + 1'b1;
        end
    end

    assign hold_reset = mr_low_reg || !sync_bus.supply_ok;

    // ------------------------------------------------------------
    // reset timeout counter
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || hold_reset) begin
            rst_cnt_reg <= '0;
        end else begin
            rst_cnt_reg <= sat_inc(rst_cnt_reg, tick);
        end
    end

    // ------------------------------------------------------------
    // kick edge detect on the synchronised level
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            kick_prev_reg <= 1'b1;
        end else begin
            kick_prev_reg <= sync_bus.kick;
        end
    end

    assign kick_fall = kick_prev_reg && !sync_bus.kick;
    // edges only count in the armed state, so reset and fault mask them
    assign fast_hit = (state_reg == WWS_ARMED) && kick_fall
        && !first_edge_reg
        && wd_cnt_reg < CW'(FAST_WINDOW_LIMIT);
    assign slow_hit = (state_reg == WWS_ARMED) && !kick_fall
        && wd_cnt_reg >= CW'(SLOW_WINDOW_LIMIT);

    // ------------------------------------------------------------
    // supervisor state machine
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_reg <= WWS_RESET;
        end else begin
            case (state_reg)
                WWS_RESET: begin
                    // one spare tick: the hold never falls short of the
                    // timeout whatever the tick phase at release
                    if (!hold_reset && rst_cnt_reg > CW'(RESET_TIMEOUT))
                        state_reg <= WWS_ARMED;
                end
                WWS_ARMED: begin
                    if (hold_reset)
                        state_reg <= WWS_RESET;
                    else if (fast_hit || slow_hit)
                        state_reg <= WWS_FAULT;
                end
                WWS_FAULT: begin
                    if (hold_reset)
                        state_reg <= WWS_RESET;
                    else if (pulse_cnt_reg >= CW'(FAULT_PULSE_LEN))
                        state_reg <= WWS_ARMED;
                end
                default: state_reg <= WWS_RESET;
            endcase
        end
    end

    // ------------------------------------------------------------
    // watchdog timer and first-edge exemption
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset || state_reg != WWS_ARMED) begin
            wd_cnt_reg <= '0;
            first_edge_reg <= 1'b1;
        end else if (kick_fall) begin
            wd_cnt_reg <= '0;
            first_edge_reg <= 1'b0;
        end else begin
            wd_cnt_reg <= sat_inc(wd_cnt_reg, tick);
        end
    end

    // fault pulse length counter
    always_ff @(posedge core_clk) begin
        if (reset || state_reg != WWS_FAULT) begin
            pulse_cnt_reg <= '0;
        end else begin
            pulse_cnt_reg <= sat_inc(pulse_cnt_reg, tick);
        end
    end

    // fault cause flags, pulse for one cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fast_fault <= 1'b0;
            slow_fault <= 1'b0;
        end else begin
            fast_fault <= fast_hit && !hold_reset;
            slow_fault <= slow_hit && !hold_reset;
        end
    end

    // ------------------------------------------------------------
    // outputs: reset never driven by a fault
    // ------------------------------------------------------------
    assign reset_out_n = (state_reg != WWS_RESET);
    assign fault_pulse_out_n_o = 1'b0; // open drain: only ever pulls low
    assign fault_pulse_out_n_oe = (state_reg == WWS_FAULT);
endmodule : wws_supervisor

// ===== wws_supervisor_properties.sv
// checker for the supervisor top-level ports
`timescale 1ns/100ps
module wws_supervisor_properties #(
    parameter int unsigned FAULT_PULSE_LEN = wws_pkg::FAULT_PULSE_TICKS,
    parameter int unsigned RESET_TIMEOUT = wws_pkg::RESET_TIMEOUT_TICKS,
    parameter int unsigned TICK_CYCLES = wws_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_above_threshold,
    input wire logic manual_reset_in_n,
    input wire logic reset_out_n,
    input wire logic fault_pulse_out_n_o,
    input wire logic fault_pulse_out_n_oe,
    input wire logic fast_fault,
    input wire logic slow_fault
);
    // ----
    // pulse window and reset hold figures in clock cycles
    // ----
    localparam int PL_LO = (FAULT_PULSE_LEN - 1) * TICK_CYCLES + 2;
    localparam int PL_HI = FAULT_PULSE_LEN * TICK_CYCLES + 1;
    localparam int RT = RESET_TIMEOUT * TICK_CYCLES;
    logic [31:0] good_reg;
    logic [31:0] oe_run_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // cycles with both pins good; saturates so it never wraps
    always_ff @(posedge core_clk) begin
        if (reset || !supply_above_threshold || !manual_reset_in_n) begin
            good_reg <= 32'h0;
        end else if (good_reg < RT) begin
            good_reg <= good_reg + 32'h1;
        end
    end
    // length of the running fault pulse; too long for a repetition count
    always_ff @(posedge core_clk) begin
        if (reset || !fault_pulse_out_n_oe) begin
            oe_run_reg <= 32'h0;
        end else begin
            oe_run_reg <= oe_run_reg + 32'h1;
        end
    end
    sequence s_hold;
        reset_out_n [*3];
    endsequence
    // a pulse cut short by a reset is legal, so only free ends count
    property p_pulse_len;
        $fell(fault_pulse_out_n_oe) && reset_out_n |->
            oe_run_reg >= PL_LO && oe_run_reg <= PL_HI;
    endproperty
    property p_fast;
        fast_fault |-> ##[0:1] fault_pulse_out_n_oe;
    endproperty
    property p_slow;
        slow_fault |-> ##[0:1] fault_pulse_out_n_oe;
    endproperty
    property p_quiet;
        !reset_out_n |-> !fault_pulse_out_n_oe && !fast_fault && !slow_fault;
    endproperty
    property p_no_reset;
        $rose(fault_pulse_out_n_oe) && good_reg >= RT |-> s_hold;
    endproperty
    // reset may only fall shortly after a pin went bad
    property p_reset_cause;
        $fell(reset_out_n) |-> good_reg < 32'h8;
    endproperty
    property p_hold;
        $rose(reset_out_n) |-> good_reg >= RT;
    endproperty
    property p_od;
        !fault_pulse_out_n_o;
    endproperty
    property p_flag;
        (fast_fault || slow_fault) |=> !(fast_fault || slow_fault);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("fault pulse length wrong");
    a_fast: assert property (p_fast)
        else $error("fast fault without pulse");
    a_slow: assert property (p_slow)
        else $error("slow fault without pulse");
    a_quiet: assert property (p_quiet)
        else $error("fault activity during reset");
    a_no_reset: assert property (p_no_reset)
        else $error("fault drove reset");
    a_reset_cause: assert property (p_reset_cause)
        else $error("reset asserted with both pins good");
    a_hold: assert property (p_hold)
        else $error("reset released too early");
    a_od: assert property (p_od)
        else $error("open-drain data not low");
    a_flag: assert property (p_flag)
        else $error("fault flag longer than one cycle");
endmodule : wws_supervisor_properties
bind wws_supervisor wws_supervisor_properties #(
    .FAULT_PULSE_LEN(FAULT_PULSE_LEN), .RESET_TIMEOUT(RESET_TIMEOUT),
    .TICK_CYCLES(TICK_CYCLES)
) i_wws_supervisor_properties (
    .core_clk(core_clk), .reset(reset),
    .supply_above_threshold(supply_above_threshold),
    .manual_reset_in_n(manual_reset_in_n), .reset_out_n(reset_out_n),
    .fault_pulse_out_n_o(fault_pulse_out_n_o),
    .fault_pulse_out_n_oe(fault_pulse_out_n_oe),
    .fast_fault(fast_fault), .slow_fault(slow_fault)
);

// ===== wws_host.sv
// host model toggling the kick pin at a set spacing
`timescale 1ns/100ps
module wws_host (
    input wire logic core_clk,
    input wire logic [15:0] gap,
    output logic watchdog_kick_in
);
    logic [15:0] cnt_reg = 16'h0;
    // one falling edge every gap cycles; gap zero stalls the host
    always @(negedge core_clk) begin
        cnt_reg <= (cnt_reg + 16'h1 >= gap) ? 16'h0 : cnt_reg + 16'h1;
        watchdog_kick_in <= (gap == 16'h0) || (cnt_reg >= (gap >> 1));
    end
endmodule : wws_host

// ===== wws_supervisor_tb.sv
// self-checking testbench for the watchdog supervisor
`timescale 1ns/100ps
module wws_supervisor_tb;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic supply_above_threshold = 1'h1;
    logic manual_reset_in_n = 1'h1;
    logic watchdog_kick_in, reset_out_n, fault_pulse_out_n_o;
    logic fault_pulse_out_n_oe, fast_fault, slow_fault;
    logic [15:0] gap = 16'h0;
    int n_fail = 0, compares = 0, n_fast = 0, n_slow = 0, k;
    typedef struct packed {logic [15:0] g; logic f; logic s;} wws_row_t;
    // spacing in cycles beside the fast and slow faults it should give
    wws_row_t rows [6] = '{'{16'h64, 1'h0, 1'h0}, '{16'h3C, 1'h0, 1'h0},
        '{16'h8C, 1'h0, 1'h0}, '{16'h0C, 1'h1, 1'h0},
        '{16'h20, 1'h1, 1'h0}, '{16'hF0, 1'h0, 1'h1}};
    // ----
    // short counts so the run stays brief
    // ----
    wws_supervisor #(.FAST_WINDOW_LIMIT(10), .SLOW_WINDOW_LIMIT(40),
        .FAULT_PULSE_LEN(5), .RESET_TIMEOUT(20), .TICK_CYCLES(4)
    ) i_wws_supervisor (.core_clk(core_clk), .reset(reset),
        .supply_above_threshold(supply_above_threshold),
        .watchdog_kick_in(watchdog_kick_in),
        .manual_reset_in_n(manual_reset_in_n), .reset_out_n(reset_out_n),
        .fault_pulse_out_n_o(fault_pulse_out_n_o),
        .fault_pulse_out_n_oe(fault_pulse_out_n_oe),
        .fast_fault(fast_fault), .slow_fault(slow_fault));
    wws_host i_wws_host (.core_clk(core_clk), .gap(gap),
        .watchdog_kick_in(watchdog_kick_in));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // fault flags stand one cycle, so tally every edge
    always @(negedge core_clk) begin
        if (fast_fault === 1'h1) n_fast++;
        if (slow_fault === 1'h1) n_slow++;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc
    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, m);
        end
    endtask : chk_bit
    // bounded wait for reset release, t counts cycles waited
    task automatic wait_up(output int t);
        t = 0;
        while (reset_out_n !== 1'h1 && t < 400) begin
            cyc(1);
            t++;
        end
    endtask : wait_up
    task automatic final_report;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    // watchdog: the whole run needs well under 10000 cycles
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
    initial begin
        cyc(20);
        reset = 1'h0;
        cyc(70);
        chk_bit(reset_out_n, 1'h0, "reset released early");
        wait_up(k);
        chk_bit(k < 60, 1'h1, "reset released late");
        foreach (rows[i]) begin
            gap = rows[i].g;
            supply_above_threshold = 1'h0;
            cyc(8);
            chk_bit(reset_out_n, 1'h0, "supply drop missed");
            supply_above_threshold = 1'h1;
            wait_up(k);
            chk_bit(k >= 80 && k < 120, 1'h1, "supply hold wrong");
            n_fast = 0;
            n_slow = 0;
            cyc(600);
            chk_bit(n_fast > 0, rows[i].f, "fast fault");
            chk_bit(n_slow > 0, rows[i].s, "slow fault");
            chk_bit(reset_out_n, 1'h1, "reset from fault");
        end
        // short low glitch must not start a reset
        manual_reset_in_n = 1'h0;
        cyc(20);
        manual_reset_in_n = 1'h1;
        cyc(40);
        chk_bit(reset_out_n, 1'h1, "glitch accepted");
        // long manual hold while the host stalls into slow faults
        gap = 16'h0;
        cyc(150);
        manual_reset_in_n = 1'h0;
        cyc(200);
        chk_bit(reset_out_n, 1'h0, "manual reset missed");
        chk_bit(fault_pulse_out_n_oe, 1'h0, "fault pin driven");
        manual_reset_in_n = 1'h1;
        wait_up(k);
        chk_bit(k >= 80, 1'h1, "manual timeout short");
        chk_bit(k < 120, 1'h1, "manual timeout long");
        final_report();
    end
endmodule : wws_supervisor_tb
